// ### common/perf_pkg.sv
// Package of register map, field positions and constants for the coherence performance counters
package perf_pkg;
   localparam int          DATA_W          = 32;
   localparam int          ADDR_W          = 12;
   localparam int          CODE_W          = 8;
   localparam int          QUAL_W          = 64;
   localparam int          NUM_EVT         = 2;
   // Byte addresses of the registers
   localparam logic [11:0] OFF_CONTROL     = 12'h910;
   localparam logic [11:0] OFF_OVERFLOW    = 12'h920;
   localparam logic [11:0] OFF_EVENT_SEL   = 12'h930;
   localparam logic [11:0] OFF_IRQ_MASK    = 12'h940;
   localparam logic [11:0] OFF_CYCLE       = 12'h980;
   localparam logic [11:0] OFF_QUAL_A_LO   = 12'h990;
   localparam logic [11:0] OFF_QUAL_A_HI   = 12'h994;
   localparam logic [11:0] OFF_COUNT_A     = 12'h998;
   localparam logic [11:0] OFF_QUAL_B_LO   = 12'h9a0;
   localparam logic [11:0] OFF_QUAL_B_HI   = 12'h9a4;
   localparam logic [11:0] OFF_COUNT_B     = 12'h9a8;
   // Control register fields
   localparam int          CTL_INT_EN      = 30;
   localparam int          CTL_OVF_STOP    = 29;
   localparam int          CTL_CLR_B       = 9;
   localparam int          CTL_RUN_B       = 8;
   localparam int          CTL_CLR_A       = 7;
   localparam int          CTL_RUN_A       = 6;
   localparam int          CTL_CLR_CYC     = 5;
   localparam int          CTL_RUN_CYC     = 4;
   localparam logic [3:0]  NUM_CNT_VALUE   = 4'h2;
   // Overflow flag positions, also the layout of the mask register
   localparam int          OVF_CYC         = 0;
   localparam int          OVF_A           = 1;
   localparam int          OVF_B           = 2;
   localparam int          OVF_W           = 3;
   // Event select fields
   localparam int          SEL_A_LSB       = 0;
   localparam int          SEL_B_LSB       = 8;
   localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;
   localparam logic [31:0] ALL_ONES        = 32'hffff_ffff;
   localparam logic [31:0] ONE_WORD        = 32'h0000_0001;
endpackage

// ### design/event_filter.sv
// Event selection and qualification for one event counter
`timescale 1ns/1ns
`default_nettype none
module event_filter
   import perf_pkg::*;
(
   input  wire logic [255:0] event_bus,
   input  wire logic [63:0]  event_attr,
   input  wire logic [7:0]   event_code,
   input  wire logic [63:0]  qualifier,
   output logic              hit
);
   // Zero qualifier counts every occurrence; otherwise at least one qualifier bit must also be set in the attributes
   always_comb begin
      hit = event_bus[event_code] && ((qualifier == 64'h0) || ((qualifier & event_attr) != 64'h0));
   end
endmodule
`default_nettype wire

// ### design/tally_counter.sv
// One 32-bit counter with write, clear, enable and overflow detect
`timescale 1ns/1ns
`default_nettype none
module tally_counter
   import perf_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        run,
   input  wire logic        inc,
   input  wire logic        clr,
   input  wire logic        wr,
   input  wire logic [31:0] wdata,
   output logic [31:0]      value_q,
   output logic             ovf_hit
);
   // Overflow is the step onto all-ones while running
   assign ovf_hit = run && inc && !wr && !clr && (value_q == (ALL_ONES - ONE_WORD));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         value_q <= 32'h0000_0000;
      end else if (wr) begin
         value_q <= wdata;
      end else if (clr) begin
         value_q <= ZERO_WORD;
      end else if (run && inc) begin
         value_q <= value_q + ONE_WORD;
      end
   end
endmodule
`default_nettype wire

// ### design/coherence_perf_counters.sv
// Performance counter block: cycle tally, two event counters, APB register file
//
// How it works
// - Second event code sits in select bits 15:8; bits 31:16 read zero.
// - First event code sits in select bits 7:0, reset to zero.
// - Thirty-two bit cycle tally, software readable and writable, reset zero.
// - Sixty-four bit qualifier for first counter, read-write, reset zero.
// - Sixty-four bit qualifier for second counter, read-write, reset zero.
// - Event counters count only selected, qualified events; read-write, reset zero.
// - Counters run only while enabled; clear with enable zeroes counter and flag.
// - Overflow flags at bits 2,1,0 set on all-ones; write one clears.
// - Stop-on-overflow clears the three counter run enables when any enabled counter overflows; interrupt enable stays set.
// - Interrupt enable raises interrupt when any overflow flag enabled in the mask register is set.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module coherence_perf_counters
   import perf_pkg::*;
(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [11:0]  paddr,
   input  wire logic [31:0]  pwdata,
   input  wire logic [3:0]   pstrb,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire logic [255:0] event_bus,
   input  wire logic [63:0]  event_attr,
   output logic              perf_irq
);
   logic [7:0]         code_a_q;
   logic [7:0]         code_b_q;
   logic [63:0]        qual_a_q;
   logic [63:0]        qual_b_q;
   logic               run_cycles_q;
   logic               run_a_q;
   logic               run_b_q;
   logic               int_en_q;
   logic               ovf_stop_q;
   logic [OVF_W-1:0]   ovf_q;
   logic [OVF_W-1:0]   mask_q;
   logic [31:0]        cyc_val;
   logic [31:0]        cnt_a_val;
   logic [31:0]        cnt_b_val;
   logic               hit_a;
   logic               hit_b;
   logic [OVF_W-1:0]   ovf_hit;
   logic               any_ovf;
   logic               acc;
   logic               wr_en;
   logic               ctl_wr;
   logic [31:0]        rdata_d;
   logic               known_d;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_DONE = 2'b10
   } bus_state_t;
   bus_state_t state_q;

   // Shared decode of an address against a given register offset
   function automatic logic hits(input logic [11:0] a, input logic [11:0] off);
      hits = (a == off);
   endfunction

   // Writes land only at the edge that samples pready high, as the master sees it
   assign acc    = psel && penable && pready;
   assign wr_en  = acc && pwrite && (pstrb == 4'hf);
   assign ctl_wr = wr_en && hits(paddr, OFF_CONTROL);

   // One wait state: pready rises after the first access cycle and falls the cycle after
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (psel && penable) begin
                  state_q <= ST_DONE;
               end
            end
            ST_DONE: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   event_filter u_filter_a (
      .event_bus  (event_bus),
      .event_attr (event_attr),
      .event_code (code_a_q),
      .qualifier  (qual_a_q),
      .hit        (hit_a)
   );
   event_filter u_filter_b (
      .event_bus  (event_bus),
      .event_attr (event_attr),
      .event_code (code_b_q),
      .qualifier  (qual_b_q),
      .hit        (hit_b)
   );

   tally_counter u_cycles (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (run_cycles_q),
      .inc     (1'b1),
      .clr     (ctl_wr && pwdata[CTL_CLR_CYC] && pwdata[CTL_RUN_CYC]),
      .wr      (wr_en && hits(paddr, OFF_CYCLE)),
      .wdata   (pwdata),
      .value_q (cyc_val),
      .ovf_hit (ovf_hit[OVF_CYC])
   );
   tally_counter u_count_a (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (run_a_q),
      .inc     (hit_a),
      .clr     (ctl_wr && pwdata[CTL_CLR_A] && pwdata[CTL_RUN_A]),
      .wr      (wr_en && hits(paddr, OFF_COUNT_A)),
      .wdata   (pwdata),
      .value_q (cnt_a_val),
      .ovf_hit (ovf_hit[OVF_A])
   );
   tally_counter u_count_b (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (run_b_q),
      .inc     (hit_b),
      .clr     (ctl_wr && pwdata[CTL_CLR_B] && pwdata[CTL_RUN_B]),
      .wr      (wr_en && hits(paddr, OFF_COUNT_B)),
      .wdata   (pwdata),
      .value_q (cnt_b_val),
      .ovf_hit (ovf_hit[OVF_B])
   );

   assign any_ovf = |ovf_hit;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_a_q <= 8'h00;
         code_b_q <= 8'h00;
      end else if (wr_en && hits(paddr, OFF_EVENT_SEL)) begin
         code_a_q <= pwdata[SEL_A_LSB +: CODE_W];
         code_b_q <= pwdata[SEL_B_LSB +: CODE_W];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qual_a_q <= 64'h0;
         qual_b_q <= 64'h0;
      end else if (wr_en) begin
         if (hits(paddr, OFF_QUAL_A_LO)) begin
            qual_a_q[31:0] <= pwdata;
         end
         if (hits(paddr, OFF_QUAL_A_HI)) begin
            qual_a_q[63:32] <= pwdata;
         end
         if (hits(paddr, OFF_QUAL_B_LO)) begin
            qual_b_q[31:0] <= pwdata;
         end
         if (hits(paddr, OFF_QUAL_B_HI)) begin
            qual_b_q[63:32] <= pwdata;
         end
      end
   end

   // enables; overflow stop wins over a same-cycle write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_cycles_q <= 1'b0;
         run_a_q      <= 1'b0;
         run_b_q      <= 1'b0;
         int_en_q     <= 1'b0;
         ovf_stop_q   <= 1'b0;
      end else begin
         if (ctl_wr) begin
            run_cycles_q <= pwdata[CTL_RUN_CYC];
            run_a_q      <= pwdata[CTL_RUN_A];
            run_b_q      <= pwdata[CTL_RUN_B];
            int_en_q     <= pwdata[CTL_INT_EN];
            ovf_stop_q   <= pwdata[CTL_OVF_STOP];
         end
         if (ovf_stop_q && any_ovf) begin
            run_cycles_q <= 1'b0;
            run_a_q      <= 1'b0;
            run_b_q      <= 1'b0;
         end
      end
   end

   // sticky flags, set beats write-one clear; clear request zeroes its flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_q <= 3'b000;
      end else begin
         for (int i = 0; i < OVF_W; i++) begin
            if (ovf_hit[i]) begin
               ovf_q[i] <= 1'b1;
            end else if (wr_en && hits(paddr, OFF_OVERFLOW) && pwdata[i]) begin
               ovf_q[i] <= 1'b0;
            end else if (ctl_wr && pwdata[CTL_RUN_CYC + 2 * i] && pwdata[CTL_CLR_CYC + 2 * i]) begin
               ovf_q[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= 3'b000;
      end else if (wr_en && hits(paddr, OFF_IRQ_MASK)) begin
         mask_q <= pwdata[OVF_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         perf_irq <= 1'b0;
      end else begin
         perf_irq <= int_en_q && |(ovf_q & mask_q);
      end
   end

   // Read mux; clear-request bits and reserved bits read zero
   always_comb begin
      rdata_d = ZERO_WORD;
      known_d = 1'b1;
      case (paddr)
         OFF_CONTROL: begin
            rdata_d[CTL_INT_EN]   = int_en_q;
            rdata_d[CTL_OVF_STOP] = ovf_stop_q;
            rdata_d[CTL_RUN_B]    = run_b_q;
            rdata_d[CTL_RUN_A]    = run_a_q;
            rdata_d[CTL_RUN_CYC]  = run_cycles_q;
            rdata_d[3:0]          = NUM_CNT_VALUE;
         end
         OFF_OVERFLOW:  rdata_d[OVF_W-1:0] = ovf_q;
         OFF_IRQ_MASK:  rdata_d[OVF_W-1:0] = mask_q;
         OFF_EVENT_SEL: rdata_d[15:0] = {code_b_q, code_a_q};
         OFF_CYCLE:     rdata_d = cyc_val;
         OFF_QUAL_A_LO: rdata_d = qual_a_q[31:0];
         OFF_QUAL_A_HI: rdata_d = qual_a_q[63:32];
         OFF_COUNT_A:   rdata_d = cnt_a_val;
         OFF_QUAL_B_LO: rdata_d = qual_b_q[31:0];
         OFF_QUAL_B_HI: rdata_d = qual_b_q[63:32];
         OFF_COUNT_B:   rdata_d = cnt_b_val;
         default:       known_d = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && penable && (state_q == ST_IDLE);
         pslverr <= psel && penable && (state_q == ST_IDLE) && !known_d;
         prdata  <= (psel && penable && !pwrite && (state_q == ST_IDLE)) ? rdata_d : ZERO_WORD;
      end
   end

   // a_irq_follows_flags
   a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
      (int_en_q && |(ovf_q & mask_q)) |=> perf_irq)
      else $error("interrupt not raised for unmasked flag");
   a_ovf_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
      ovf_hit[OVF_A] |=> ovf_q[OVF_A] && cnt_a_val == ALL_ONES)
      else $error("overflow flag or value wrong");
   a_stop_on_ovf: assert property (@(posedge pclk) disable iff (!presetn)
      (ovf_stop_q && any_ovf) |=> !run_a_q && !run_b_q && !run_cycles_q)
      else $error("counters not stopped on overflow");
   a_cycle_counts: assert property (@(posedge pclk) disable iff (!presetn)
      (run_cycles_q && !ctl_wr && !(wr_en && hits(paddr, OFF_CYCLE))) |=> cyc_val == $past(cyc_val) + ONE_WORD)
      else $error("cycle tally did not advance");
   a_halt_holds: assert property (@(posedge pclk) disable iff (!presetn)
      (!run_a_q && !wr_en) |=> cnt_a_val == $past(cnt_a_val))
      else $error("stopped counter moved");
   a_event_b_inc: assert property (@(posedge pclk) disable iff (!presetn)
      (run_b_q && hit_b && !wr_en) |=> cnt_b_val == $past(cnt_b_val) + ONE_WORD)
      else $error("event counter missed an event");
   a_write_wins: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && hits(paddr, OFF_COUNT_A)) |=> cnt_a_val == $past(pwdata))
      else $error("counter write lost");
   a_sel_store: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && hits(paddr, OFF_EVENT_SEL)) |=> code_b_q == $past(pwdata[15:8]) && code_a_q == $past(pwdata[7:0]))
      else $error("event select not stored");
   a_qual_store: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && hits(paddr, OFF_QUAL_A_HI)) |=> qual_a_q[63:32] == $past(pwdata))
      else $error("qualifier not stored");
   a_clear_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (ctl_wr && pwdata[CTL_CLR_B] && pwdata[CTL_RUN_B] && !ovf_hit[OVF_B]) |=> cnt_b_val == ZERO_WORD && !ovf_q[OVF_B])
      else $error("clear request failed");
   // Overflow must reach the pin two edges later unless mask or enable is rewritten
   a_irq_on_ovf: assert property (@(posedge pclk) disable iff (!presetn)
      (int_en_q && |(ovf_hit & mask_q) && !ctl_wr && !(wr_en && hits(paddr, OFF_IRQ_MASK))) |=> ##1 perf_irq)
      else $error("interrupt missed an overflow");
   c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(perf_irq));
   c_stop: cover property (@(posedge pclk) disable iff (!presetn) ovf_stop_q && any_ovf);
   c_count_b: cover property (@(posedge pclk) disable iff (!presetn) run_b_q && hit_b);
endmodule
`default_nettype wire

// ### tb/tb_coherence_perf_counters.sv
// Self-checking bench for the coherence performance counter block
`timescale 1ns/1ns
`default_nettype none
module tb_coherence_perf_counters
   import perf_pkg::*;
;
   logic         pclk;
   logic         presetn;
   logic         psel;
   logic         penable;
   logic         pwrite;
   logic [11:0]  paddr;
   logic [31:0]  pwdata;
   logic [3:0]   pstrb;
   logic [31:0]  prdata;
   logic         pready;
   logic         pslverr;
   logic [255:0] event_bus;
   logic [63:0]  event_attr;
   logic         perf_irq;
   logic [31:0]  rd;
   logic [31:0]  v;
   logic         err;
   int           fails;
   int           num_checks;
   logic [11:0]  regs [10] = '{OFF_OVERFLOW, OFF_EVENT_SEL, OFF_IRQ_MASK, OFF_CYCLE, OFF_QUAL_A_LO,
                               OFF_QUAL_A_HI, OFF_COUNT_A, OFF_QUAL_B_LO, OFF_QUAL_B_HI, OFF_COUNT_B};
   // Event lines 5 and 200 are the selected codes, line 6 is noise
   localparam logic [255:0] EV_A = 256'h1 << 5;
   localparam logic [255:0] EV_AB = (256'h1 << 5) | (256'h1 << 200) | (256'h1 << 6);

   coherence_perf_counters uut (
      .pclk       (pclk),
      .presetn    (presetn),
      .psel       (psel),
      .penable    (penable),
      .pwrite     (pwrite),
      .paddr      (paddr),
      .pwdata     (pwdata),
      .pstrb      (pstrb),
      .prdata     (prdata),
      .pready     (pready),
      .pslverr    (pslverr),
      .event_bus  (event_bus),
      .event_attr (event_attr),
      .perf_irq   (perf_irq)
   );

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   task automatic print_verdict();
      if (fails == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One APB transfer; request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20 && pready !== 1'b1; n++)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20) begin
         fails++;
         $display("[FAIL] pready expected 1 seen %b", pready);
         print_verdict();
      end
   endtask

   task automatic rchk(input string name, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(name, exp, rd);
      check("slverr", ZERO_WORD, {31'h0, err});
   endtask

   // Holds the events for n sampled edges, then drops them
   task automatic pulse(input logic [255:0] bus, input logic [63:0] attr, input int n);
      repeat (n) begin
         @(posedge pclk);
         event_bus <= bus;
         event_attr <= attr;
      end
      @(posedge pclk);
      event_bus <= '0;
   endtask

   task automatic reset_values();
      rchk("control", OFF_CONTROL, {28'h0, NUM_CNT_VALUE});
      for (int i = 0; i < 10; i++)
         rchk("reset_reg", regs[i], ZERO_WORD);
   endtask

   task automatic read_write();
      apb(1'b1, OFF_EVENT_SEL, ALL_ONES);
      rchk("event_select", OFF_EVENT_SEL, 32'h0000_ffff);
      for (int i = 3; i < 10; i++)
         apb(1'b1, regs[i], 32'hc3a5_5a30 + i);
      for (int i = 3; i < 10; i++)
         rchk("rw_reg", regs[i], 32'hc3a5_5a30 + i);
      // Partial strobes must leave the register untouched
      pstrb <= 4'h3;
      apb(1'b1, OFF_CYCLE, ZERO_WORD);
      pstrb <= 4'hf;
      rchk("partial_strobe", OFF_CYCLE, 32'hc3a5_5a33);
      apb(1'b1, 12'h900, ALL_ONES);
      check("unmapped_wr_err", 32'h1, {31'h0, err});
      apb(1'b0, 12'h900, 32'h0);
      check("unmapped_rd_err", 32'h1, {31'h0, err});
      check("unmapped_rd", ZERO_WORD, rd);
   endtask

   task automatic cycle_wrap();
      apb(1'b1, OFF_CYCLE, 32'hffff_fffd);
      apb(1'b1, OFF_CONTROL, 32'h0000_0010);
      apb(1'b1, OFF_CONTROL, ZERO_WORD);
      rchk("overflow_cycles", OFF_OVERFLOW, 32'h1);
      apb(1'b0, OFF_CYCLE, 32'h0);
      v = rd;
      check("tally_wrapped", ONE_WORD, {31'h0, v < 32'h100});
      rchk("tally_held", OFF_CYCLE, v);
      apb(1'b1, OFF_OVERFLOW, ONE_WORD);
      rchk("overflow_w1c", OFF_OVERFLOW, ZERO_WORD);
   endtask

   task automatic event_count();
      apb(1'b1, OFF_EVENT_SEL, 32'h0000_c805);
      apb(1'b1, OFF_QUAL_A_LO, ZERO_WORD);
      apb(1'b1, OFF_QUAL_A_HI, ZERO_WORD);
      apb(1'b1, OFF_QUAL_B_LO, 32'h0000_0010);
      apb(1'b1, OFF_QUAL_B_HI, ZERO_WORD);
      apb(1'b1, OFF_COUNT_A, ZERO_WORD);
      apb(1'b1, OFF_COUNT_B, ZERO_WORD);
      apb(1'b1, OFF_CONTROL, 32'h0000_0140);
      pulse(EV_AB, 64'h10, 3);
      pulse(EV_AB, 64'h01, 4);
      apb(1'b1, OFF_CONTROL, ZERO_WORD);
      pulse(EV_AB, 64'h10, 2);
      rchk("count_a", OFF_COUNT_A, 32'h7);
      rchk("count_b", OFF_COUNT_B, 32'h3);
   endtask

   task automatic overflow_stop();
      apb(1'b1, OFF_COUNT_A, 32'hffff_fffe);
      apb(1'b1, OFF_IRQ_MASK, 32'h7);
      apb(1'b1, OFF_CONTROL, 32'h6000_0140);
      pulse(EV_A, 64'h0, 2);
      rchk("count_a_stop", OFF_COUNT_A, ALL_ONES);
      rchk("control_stop", OFF_CONTROL, 32'h6000_0002);
      rchk("overflow_a", OFF_OVERFLOW, 32'h2);
      check("irq_set", ONE_WORD, {31'h0, perf_irq});
      apb(1'b1, OFF_IRQ_MASK, ZERO_WORD);
      rchk("overflow_kept", OFF_OVERFLOW, 32'h2);
      check("irq_masked", ZERO_WORD, {31'h0, perf_irq});
      apb(1'b1, OFF_IRQ_MASK, 32'h2);
      rchk("mask", OFF_IRQ_MASK, 32'h2);
      check("irq_unmasked", ONE_WORD, {31'h0, perf_irq});
      // Clear request with run zeroes the counter and its flag
      apb(1'b1, OFF_CONTROL, 32'h4000_00c0);
      rchk("count_a_clr", OFF_COUNT_A, ZERO_WORD);
      rchk("overflow_clr", OFF_OVERFLOW, ZERO_WORD);
      rchk("control_clr", OFF_CONTROL, 32'h4000_0042);
      check("irq_clr", ZERO_WORD, {31'h0, perf_irq});
   endtask

   // Second reset in mid-run, with a counter still enabled, must restore every register
   task automatic mid_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      check("irq_in_reset", ZERO_WORD, {31'h0, perf_irq});
      presetn <= 1'b1;
      reset_values();
   endtask

   initial begin
      fails = 0;
      num_checks = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hf;
      event_bus = '0;
      event_attr = '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      reset_values();
      read_write();
      cycle_wrap();
      event_count();
      overflow_stop();
      mid_reset();
      print_verdict();
   end
endmodule
`default_nettype wire
